// ===== spp_params.svh
// Register offsets, field positions and reset values of the serial port pin control
// Function
// - Latch writes drive output pins; latch reads return live pin levels.
// - Every SPI pin works as general-purpose I/O.
// - Transmit pin is port output, receive pin port input, while channel disabled.
// - Assignment bits hand chip-selects, MOSI, MISO to the SPI engine when set while SPI enabled.
// - Serial clock pin ignores assignment; reverts to port I/O when SPI disabled.
// - Pins assigned to port I/O follow only direction and data registers.
// - Assignment byte never touches the asynchronous channels or their pins.
// - Direction bits set SPI pins output when set, input when clear, always.
// - Reset leaves all SPI pins as general-purpose inputs.
// - Direction byte ignores async pins: transmit always out, receive always in.
// - Assignment byte bits 15:8 and direction byte share one 16-bit register.
`ifndef SPP_PARAMS_SVH
`define SPP_PARAMS_SVH

`define SPP_ADDR_DATA 4'h0
`define SPP_ADDR_CTRL 4'h4

`define SPP_BIT_MISO 0
`define SPP_BIT_MOSI 1
`define SPP_BIT_SCK 2
`define SPP_BIT_PCS0 3
`define SPP_BIT_PCS3 6
`define SPP_BIT_TXD1 8
`define SPP_BIT_RXD1 9
`define SPP_BIT_TXD2 10
`define SPP_BIT_RXD2 11

`define SPP_ASN_PCS3 1
`define SPP_ASN_PCS0 4
`define SPP_ASN_MOSI 6
`define SPP_ASN_MISO 7

`define SPP_DATA_MASK 16'h0f7f
`define SPP_DATA_RESET 16'h0500
`define SPP_DIR_MASK 8'h7f
`define SPP_ASN_MASK 8'hde
`define SPP_CTRL_RESET 16'h0000

`endif

// ===== spp_pkg.sv
// Types shared by the serial port pin control
package spp_pkg;
  typedef logic [6:0] spp_qpin_type;
  typedef logic [1:0] spp_async_type;
  typedef logic [15:0] spp_word_type;
endpackage

// ===== spp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module spp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_stage2;

  if (WIDTH < 1) begin : g_check
    $error("spp_sync needs WIDTH of at least one");
  end

  always_comb begin
    next_stage1 = async_i;
    next_stage2 = stage1;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stage1 <= '0;
      stage2 <= '0;
    end else begin
      stage1 <= next_stage1;
      stage2 <= next_stage2;
    end
  end

  assign sync_o = stage2;
endmodule

// ===== spp_pin_control.sv
// Pin control of the serial module port with a classic Wishbone register slave
//
// Local design decisions: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "spp_params.svh"
module spp_pin_control
  import spp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // SPI engine side, same clock
  input wire logic qspi_enable_i,
  input wire logic [6:0] qspi_pin_out_i,
  output logic [6:0] qspi_pin_in_o,
  // Async serial channels side, same clock
  input wire logic [1:0] async_tx_enable_i,
  input wire logic [1:0] async_rx_enable_i,
  input wire logic [1:0] async_tx_data_i,
  output logic [1:0] async_rx_data_o,
  // Port pins
  input wire logic [6:0] qpin_i,
  output logic [6:0] qpin_o,
  output logic [6:0] qpin_oe_n_o,
  output logic [1:0] async_transmit_pin_o,
  input wire logic [1:0] async_receive_pin_i
);

  // Pin counts are fixed by the port list; these checks keep the shared macros in step
  localparam int QPIN_COUNT = 7;
  localparam int ASYNC_COUNT = 2;
  localparam int WORD_BITS = 16;
  localparam int PCS_COUNT = 4;

  if ($bits(spp_qpin_type) != QPIN_COUNT) begin : g_qpin_check
    $error("spp_pin_control needs a seven-bit SPI pin type");
  end
  if ($bits(spp_async_type) != ASYNC_COUNT) begin : g_async_check
    $error("spp_pin_control needs a two-bit channel type");
  end
  if ($bits(spp_word_type) != WORD_BITS) begin : g_word_check
    $error("spp_pin_control needs a sixteen-bit register word");
  end
  if (`SPP_BIT_PCS3 - `SPP_BIT_PCS0 + 1 != PCS_COUNT) begin : g_pcs_check
    $error("chip-select data bits must be four in a row");
  end
  if (`SPP_ASN_PCS0 - `SPP_ASN_PCS3 + 1 != PCS_COUNT) begin : g_asn_check
    $error("chip-select assignment bits must be four in a row");
  end
  if (`SPP_BIT_PCS3 >= QPIN_COUNT || `SPP_BIT_SCK >= QPIN_COUNT) begin : g_pin_check
    $error("SPI pin bits lie outside the port pins");
  end
  // Channel bits share the data word with the SPI pins and must not overlap them
  if (`SPP_BIT_TXD1 < QPIN_COUNT || `SPP_BIT_RXD2 >= WORD_BITS) begin : g_chan_check
    $error("channel bits must sit above the SPI pins in the data word");
  end
  if ((`SPP_DATA_MASK & 16'h007f) != 16'h007f) begin : g_latch_check
    $error("every SPI pin needs a latch bit");
  end
  if ((`SPP_DATA_RESET & ~`SPP_DATA_MASK) != 16'h0000) begin : g_reset_check
    $error("data latch reset sets bits that never store");
  end
  // Transmit pins idle high out of reset while their channels are off
  if (((`SPP_DATA_RESET >> `SPP_BIT_TXD1) & 16'h0001) != 16'h0001 ||
      ((`SPP_DATA_RESET >> `SPP_BIT_TXD2) & 16'h0001) != 16'h0001) begin : g_txd_check
    $error("data latch reset must set both transmit bits");
  end
  if ((`SPP_DATA_MASK & 16'hf080) != 16'h0000) begin : g_mask_check
    $error("data latch must keep bit 7 and bits 15 to 12 clear");
  end
  if ((`SPP_ASN_MASK & 8'h21) != 8'h00 ||
      (`SPP_DIR_MASK & 8'h80) != 8'h00) begin : g_ctrl_check
    $error("reserved control bits must stay clear");
  end
  if (`SPP_CTRL_RESET != 16'h0000) begin : g_ctrl_reset_check
    $error("reset must leave every SPI pin a port input");
  end
  if (`SPP_ADDR_DATA == `SPP_ADDR_CTRL) begin : g_addr_check
    $error("data and control registers need distinct offsets");
  end

  // Byte-lane merge of a 16-bit register
  function automatic spp_word_type lane_merge(input spp_word_type old_val,
                                              input spp_word_type new_val,
                                              input logic [1:0] sel,
                                              input spp_word_type mask);
    spp_word_type res;
    res = old_val;
    if (sel[0]) begin
      res[7:0] = new_val[7:0];
    end
    if (sel[1]) begin
      res[15:8] = new_val[15:8];
    end
    return res & mask;
  endfunction

  // Assignment bit that hands pin k (data bit order) to the engine
  function automatic logic pin_assigned(input logic [7:0] asn, input int k);
    logic res;
    res = 1'b0;
    if (k == `SPP_BIT_MISO) begin
      res = asn[`SPP_ASN_MISO];
    end else if (k == `SPP_BIT_MOSI) begin
      res = asn[`SPP_ASN_MOSI];
    end else if (k >= `SPP_BIT_PCS0 && k <= `SPP_BIT_PCS3) begin
      // Chip-select order is reversed between data and assignment bytes
      res = asn[`SPP_ASN_PCS0 - (k - `SPP_BIT_PCS0)];
    end
    return res;
  endfunction

  // Engine claim on SPI pin k; the serial clock ignores the assignment byte
  function automatic logic engine_has_pin(input logic enable, input logic [7:0] asn,
                                          input int k);
    logic res;
    if (k == `SPP_BIT_SCK) begin
      res = enable;
    end else begin
      res = enable & pin_assigned(asn, k);
    end
    return res;
  endfunction

  // Register decode shared by the write path and the read path
  function automatic logic reg_hit(input logic [3:0] adr, input logic [3:0] offset);
    return adr == offset;
  endfunction

  spp_word_type data_latch;
  spp_word_type ctrl_reg;
  spp_word_type next_data_latch;
  spp_word_type next_ctrl_reg;
  logic [31:0] next_dat;
  logic next_ack;
  logic [31:0] dat_q;
  logic ack_q;

  spp_qpin_type qpin_sync;
  spp_async_type rxd_sync;
  spp_qpin_type qpin_out_val;
  spp_qpin_type engine_owns;
  logic [7:0] direction;
  logic [7:0] assignment;
  spp_async_type txd_val;
  spp_word_type pin_levels;
  // Latch views and register decode
  spp_qpin_type latch_qpins;
  spp_async_type latch_txd;
  logic hit_data;
  logic hit_ctrl;

  logic req;
  logic wr;

  spp_sync #(
    .WIDTH(7)
  ) u_sync_qpin (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(qpin_i),
    .sync_o(qpin_sync)
  );

  spp_sync #(
    .WIDTH(2)
  ) u_sync_rxd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i(async_receive_pin_i),
    .sync_o(rxd_sync)
  );

  assign assignment = ctrl_reg[15:8];
  assign direction = ctrl_reg[7:0];

  // Latch fields that drive pins while the port owns them
  assign latch_qpins = data_latch[6:0];
  assign latch_txd[0] = data_latch[`SPP_BIT_TXD1];
  assign latch_txd[1] = data_latch[`SPP_BIT_TXD2];

  // Pin ownership and drive for the seven SPI pins
  always_comb begin
    for (int k = 0; k < QPIN_COUNT; k++) begin
      engine_owns[k] = engine_has_pin(qspi_enable_i, assignment, k);
      // Port-owned pins take the latch only, engine output ignored
      qpin_out_val[k] = engine_owns[k] ? qspi_pin_out_i[k] : latch_qpins[k];
    end
  end

  assign qpin_o = qpin_out_val;
  // Direction governs both engine and port use
  assign qpin_oe_n_o = ~direction[6:0];
  // Engine sees every pin, owned or not, and ignores those it does not own
  assign qspi_pin_in_o = qpin_sync;

  // Async pins: direction and assignment bytes play no part here
  always_comb begin
    txd_val[0] = async_tx_enable_i[0] ? async_tx_data_i[0] : latch_txd[0];
    txd_val[1] = async_tx_enable_i[1] ? async_tx_data_i[1] : latch_txd[1];
  end

  assign async_transmit_pin_o = txd_val;
  // Receiver sees the pin only while enabled and zero otherwise; the pin stays readable as a port input
  assign async_rx_data_o = rxd_sync & async_rx_enable_i;

  // A pin change reaches a read three clocks later: two sync flops, one read flop
  // Live pin image for reads
  always_comb begin
    pin_levels = 16'h0000;
    pin_levels[6:0] = qpin_sync;
    pin_levels[`SPP_BIT_TXD1] = txd_val[0];
    pin_levels[`SPP_BIT_RXD1] = rxd_sync[0];
    pin_levels[`SPP_BIT_TXD2] = txd_val[1];
    pin_levels[`SPP_BIT_RXD2] = rxd_sync[1];
    pin_levels = pin_levels & `SPP_DATA_MASK;
  end

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  // Decode is exact on the four address bits; other offsets answer with zero
  assign hit_data = reg_hit(wb_adr_i, `SPP_ADDR_DATA);
  assign hit_ctrl = reg_hit(wb_adr_i, `SPP_ADDR_CTRL);

  // Data latch next state; a write stores at the edge that takes the request
  always_comb begin
    next_data_latch = data_latch;
    if (wr && hit_data) begin
      next_data_latch = lane_merge(data_latch, wb_dat_i[15:0], wb_sel_i[1:0],
                                   `SPP_DATA_MASK);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_latch <= `SPP_DATA_RESET;
    end else begin
      data_latch <= next_data_latch;
    end
  end

  // Control word next state
  always_comb begin
    next_ctrl_reg = ctrl_reg;
    if (wr && hit_ctrl) begin
      // Reserved assignment bits 0 and 5 and direction bit 7 stay zero
      next_ctrl_reg = lane_merge(ctrl_reg, wb_dat_i[15:0], wb_sel_i[1:0],
                                 {`SPP_ASN_MASK, `SPP_DIR_MASK});
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= `SPP_CTRL_RESET;
    end else begin
      ctrl_reg <= next_ctrl_reg;
    end
  end

  // Bus answer: one wait state for every access, mapped or not
  // Ack drops the cycle after it, so a held strobe is taken again every second clock
  always_comb begin
    next_ack = req;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= next_ack;
    end
  end

  // Read data stands with ack only; unmapped reads and writes return zero
  always_comb begin
    next_dat = 32'h0000_0000;
    if (req && !wb_we_i) begin
      if (hit_data) begin
        next_dat = {16'h0000, pin_levels};
      end else if (hit_ctrl) begin
        next_dat = {16'h0000, ctrl_reg};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= 32'h0000_0000;
    end else begin
      dat_q <= next_dat;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
endmodule

// ===== spp_pin_control_props.sv
// Port assertions for the serial port pin control
`timescale 1ns/1ps
module spp_pin_control_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic qspi_enable_i,
  input wire logic [6:0] qspi_pin_out_i,
  input wire logic [1:0] async_tx_enable_i,
  input wire logic [1:0] async_tx_data_i,
  input wire logic [6:0] qpin_o,
  input wire logic [6:0] qpin_oe_n_o,
  input wire logic [1:0] async_transmit_pin_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (req |=> wb_ack_o)
    else $error("request not answered next cycle");
  dir_write_a: assert property (req && wb_we_i && wb_adr_i == 4'h4 && wb_sel_i[0]
    |=> qpin_oe_n_o == ~$past(wb_dat_i[6:0])) else $error("direction write not applied");
  data_zero_a: assert property (req && !wb_we_i && wb_adr_i == 4'h0
    |=> wb_dat_o[15:12] == 4'h0 && !wb_dat_o[7]) else $error("reserved data bits nonzero");
  unmapped_zero_a: assert property (req && !wb_we_i && wb_adr_i != 4'h0 && wb_adr_i != 4'h4
    |=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  tx_own_a: assert property (async_tx_enable_i == 2'b11
    |-> async_transmit_pin_o == async_tx_data_i) else $error("transmit pin not channel owned");
  sck_own_a: assert property (qspi_enable_i |-> qpin_o[2] == qspi_pin_out_i[2])
    else $error("serial clock pin not engine owned");
  oe_reset_a: assert property ($fell(rst_i) |-> qpin_oe_n_o == 7'h7f)
    else $error("pins not inputs after reset");
  cover property (wb_ack_o && wb_we_i);
  cover property (qspi_enable_i && qpin_oe_n_o == 7'h00);
  cover property (async_tx_enable_i == 2'b11);
endmodule
bind spp_pin_control spp_pin_control_props i_spp_pin_control_props (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o),
  .qspi_enable_i(qspi_enable_i),
  .qspi_pin_out_i(qspi_pin_out_i),
  .async_tx_enable_i(async_tx_enable_i),
  .async_tx_data_i(async_tx_data_i),
  .qpin_o(qpin_o),
  .qpin_oe_n_o(qpin_oe_n_o),
  .async_transmit_pin_o(async_transmit_pin_o)
);

// ===== spp_pins_model.sv
// Far devices wired to the port pins
`timescale 1ns/1ps
module spp_pins_model (
  input wire logic [6:0] qpin_o,
  input wire logic [6:0] qpin_oe_n_o,
  input wire logic [6:0] ext_drive_i,
  output logic [6:0] qpin_i
);
  // Driven pins loop back; released pins follow the far device
  assign qpin_i = (qpin_o & ~qpin_oe_n_o) | (ext_drive_i & qpin_oe_n_o);
endmodule

// ===== spp_pin_control_tb.sv
// Self-checking bench for the serial port pin control
`timescale 1ns/1ps
module spp_pin_control_tb;
  import spp_pkg::*;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, qen = 1'b0, ack;
  logic [3:0] adr = 4'h0, sel = 4'h3;
  logic [31:0] wdat = 32'h0, rdat;
  logic [6:0] qout = 7'h00, ext = 7'h00, qin, qo, oen, qpi;
  logic [1:0] txe = 2'b00, rxe = 2'b00, txd = 2'b00, rxp = 2'b00, rxo, txp;
  int bad_count = 0, checks_done = 0;
  spp_pin_control i_spp_pin_control (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .qspi_enable_i(qen), .qspi_pin_out_i(qout),
    .qspi_pin_in_o(qpi), .async_tx_enable_i(txe), .async_rx_enable_i(rxe),
    .async_tx_data_i(txd), .async_rx_data_o(rxo), .qpin_i(qin), .qpin_o(qo),
    .qpin_oe_n_o(oen), .async_transmit_pin_o(txp), .async_receive_pin_i(rxp));
  spp_pins_model i_spp_pins_model (.qpin_o(qo), .qpin_oe_n_o(oen), .ext_drive_i(ext),
    .qpin_i(qin));
  always #20 clk_i = ~clk_i;
  task automatic check(input spp_word_type got, input spp_word_type exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input spp_word_type d,
    output spp_word_type q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0, d};
    @(posedge clk_i);
    // Only the watchdog ends a wait for ack
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [3:0] a, input spp_word_type d);
    spp_word_type q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input spp_word_type e);
    spp_word_type q;
    wb(1'b0, a, 16'h0, q);
    check(q, e);
  endtask
  task automatic t_reset;
    rd(4'h0, 16'h0500);
    rd(4'h4, 16'h0000);
    rd(4'h8, 16'h0000);
    check({9'h0, oen}, 16'h007f);
  endtask
  task automatic t_gpio;
    wr(4'h0, 16'hffff);
    wr(4'h4, 16'h007f);
    rxp <= 2'b11;
    repeat (4) @(posedge clk_i);
    check({9'h0, qo}, 16'h007f);
    check({9'h0, qpi}, 16'h007f);
    rd(4'h0, 16'h0f7f);
    ext <= 7'h7f;
    wr(4'h0, 16'h0000);
    wr(4'h4, 16'h0055);
    repeat (3) @(posedge clk_i);
    check({9'h0, oen}, 16'h002a);
    rd(4'h0, 16'h0a2a);
  endtask
  task automatic t_assign;
    logic [7:0] abit[6] = '{8'h02, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80};
    logic [15:0] pbit[6] = '{16'h40, 16'h20, 16'h10, 16'h08, 16'h02, 16'h01};
    wr(4'h0, 16'hffff);
    qen <= 1'b1;
    wr(4'h4, 16'hffff);
    rd(4'h4, 16'hde7f);
    for (int i = 0; i < 6; i++) begin
      wr(4'h4, {abit[i], 8'h7f});
      check({9'h0, qo}, 16'h007b & ~pbit[i]);
    end
    qen <= 1'b0;
    @(posedge clk_i);
    check({9'h0, qo}, 16'h007f);
    sel <= 4'h2;
    wr(4'h4, 16'h0000);
    sel <= 4'h3;
    rd(4'h4, 16'h007f);
  endtask
  task automatic t_async;
    ext <= 7'h00;
    wr(4'h4, 16'hff00);
    wr(4'h0, 16'h0100);
    check({14'h0, txp}, 16'h0001);
    txe <= 2'b11;
    txd <= 2'b10;
    rxe <= 2'b11;
    rxp <= 2'b01;
    repeat (4) @(posedge clk_i);
    check({14'h0, txp}, 16'h0002);
    check({14'h0, rxo}, 16'h0001);
    rd(4'h0, 16'h0600);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_gpio();
    t_assign();
    t_async();
    stop_test();
  end
  // Whole run needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end
endmodule
